// >>> rtl/jump_stop_addressing_ctrl.sv
// Instruction decode, address resolution and jump group execution
`timescale 1ns/1ns
module jump_stop_addressing_ctrl (
	input  wire logic        clk_in,               // 250 MHz clock
	input  wire logic        sys_rst_in,           // Master clear, sync high
	input  wire logic [5:0]  console_keys_in,      // Jump keys 1..6, async
	input  wire logic        restart_in,           // Go after halt, async
	input  wire logic [23:0] acc_in,               // Accumulator contents
	input  wire logic [23:0] aux_in,               // Auxiliary register
	input  wire logic        exec_done_in,         // Execute unit finished
	input  wire logic        idx_wr_in,            // Index load strobe from execute unit
	input  wire logic [1:0]  idx_sel_in,           // Index to load, zero ignored
	input  wire logic [14:0] idx_wdata_in,         // Value for the loaded index
	output logic             mem_rd_out,           // Storage read strobe
	output logic             mem_wr_out,           // Storage write strobe
	output logic [14:0]      mem_addr_out,         // Storage address
	output logic [23:0]      mem_wdata_out,        // Storage write word
	input  wire logic [23:0] mem_rdata_in,         // Storage read word, next cycle
	output logic [23:0]      func_reg_out,         // Instruction being run
	output logic [14:0]      prog_addr_out,        // Program address register
	output logic [14:0]      exec_addr_out,        // Resolved execution address
	output logic [14:0]      operand_out,          // Immediate operand or count
	output logic             exec_req_out,         // Hand-off to execute unit
	output logic             halted_out,           // Processor stopped
	output logic [14:0]      index1_out,           // Index register 1
	output logic [14:0]      index2_out,           // Index register 2
	output logic [14:0]      index3_out,           // Index register 3
	output logic [3:0]       indir_levels_out      // Levels in last resolution
);
	////////////////////////////////////////////////////////////////////////////////
	// Ones-complement 15-bit adder with end-around carry, no negative zero
	function automatic logic [14:0] oc_add(input logic [14:0] a, input logic [14:0] b);
		logic [15:0] s;
		logic [14:0] r;
		s = {1'b0, a} + {1'b0, b};
		r = s[14:0] + {14'h0000, s[15]};
		// Negative zero folds to positive zero
		if (r == 15'h7fff) begin
			r = 15'h0000;
		end
		return r;
	endfunction : oc_add

	// Ones-complement 24-bit zero test, both zeros
	function automatic logic is_zero24(input logic [23:0] v);
		return (v == 24'h000000) || (v == 24'hffffff);
	endfunction : is_zero24

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for pin inputs
	logic [5:0] keys_s1_reg;      // First stage, keys
	logic [5:0] keys_reg;         // Second stage, keys
	logic       go_s1_reg;        // First stage, restart
	logic       go_reg;           // Second stage, restart

	// Two flops on asynchronous console inputs
	always_ff @(posedge clk_in) begin
		keys_s1_reg <= console_keys_in;
		keys_reg    <= keys_s1_reg;
		go_s1_reg   <= restart_in;
		go_reg      <= go_s1_reg;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State and registers
	jump_ctrl_pkg::ctrl_state_e state_reg;   // Control state
	jump_ctrl_pkg::ctrl_state_e state_next;
	logic [23:0] func_reg;                    // Function register
	logic [14:0] paddr_reg;                   // Program address register
	logic [14:0] fetch_addr_reg;              // Address being fetched
	logic [14:0] ea_reg;                      // Working effective address
	logic [14:0] idx_reg [1:3];               // Index registers
	logic [3:0]  levels_reg;                  // Indirect level count

	// Decoded fields of the word arriving from storage
	logic [23:0] w;
	logic [5:0]  fn;
	logic [1:0]  bsel;
	logic [2:0]  jsel;
	logic [1:0]  zc;
	logic        amode;
	logic        sub;
	logic [14:0] mfld;
	logic [14:0] bval;
	logic [14:0] p_plus1;

	always_comb begin
		w = mem_rdata_in;
		fn = w[jump_ctrl_pkg::FUNC_HI:jump_ctrl_pkg::FUNC_LO];
		amode = w[jump_ctrl_pkg::MODE_BIT];
		bsel = w[jump_ctrl_pkg::IDX_HI:jump_ctrl_pkg::IDX_LO];
		jsel = w[jump_ctrl_pkg::COND_HI:jump_ctrl_pkg::COND_LO];
		sub = w[jump_ctrl_pkg::SUB_BIT];
		zc = w[jump_ctrl_pkg::ZCOND_HI:jump_ctrl_pkg::ZCOND_LO];
		mfld = w[14:0];
		bval = (bsel == 2'h0) ? 15'h0000 : idx_reg[bsel];
		p_plus1 = paddr_reg + 15'h0001;
	end

	// Condition evaluation for accumulator jumps
	logic        cmp_true;
	logic [23:0] diff;
	always_comb begin
		diff = acc_in - aux_in;
		cmp_true = 1'b0;
		if (!sub) begin
			unique case (zc)
				jump_ctrl_pkg::cond_equal:            cmp_true = is_zero24(acc_in);
				jump_ctrl_pkg::cond_unequal:          cmp_true = !is_zero24(acc_in);
				jump_ctrl_pkg::cond_greater_or_equal: cmp_true = !acc_in[23];
				jump_ctrl_pkg::cond_less:             cmp_true = acc_in[23];
			endcase
		end else begin
			unique case (zc)
				jump_ctrl_pkg::cond_equal:   cmp_true = (acc_in == aux_in) ||
					(is_zero24(acc_in) && is_zero24(aux_in));
				jump_ctrl_pkg::cond_unequal: cmp_true = !((acc_in == aux_in) ||
					(is_zero24(acc_in) && is_zero24(aux_in)));
				jump_ctrl_pkg::cond_greater_or_equal:
					cmp_true = (acc_in[23] == aux_in[23]) ? !diff[23] : !acc_in[23];
				jump_ctrl_pkg::cond_less:
					cmp_true = (acc_in[23] == aux_in[23]) ? diff[23] : acc_in[23];
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode outcome for the instruction word in ST_DECODE
	logic        dec_jump;     // Redirect to fetch at dec_target
	logic [14:0] dec_target;
	logic        dec_indir;    // Start indirect chain
	logic        dec_halt;
	logic        dec_rtj;
	logic        dec_idx_wr;
	logic [14:0] dec_idx_val;
	always_comb begin
		dec_jump = 1'b1;
		dec_target = p_plus1;
		dec_indir = 1'b0;
		dec_halt = 1'b0;
		dec_rtj = 1'b0;
		dec_idx_wr = 1'b0;
		dec_idx_val = bval;
		unique case (fn)
			jump_ctrl_pkg::FN_STOP: begin
				if (jsel == jump_ctrl_pkg::SEL_HALT) begin
					dec_halt = 1'b1;
					dec_jump = 1'b0;
					dec_target = mfld;
				end else if (jsel == jump_ctrl_pkg::SEL_RTJ) begin
					dec_rtj = 1'b1;
					dec_jump = 1'b0;
					dec_target = mfld + 15'h0001;
				end else if (keys_reg[jsel - 3'h1]) begin
					dec_target = mfld;
				end
			end
			jump_ctrl_pkg::FN_UJUMP: begin
				dec_target = (bsel == 2'h0) ? mfld : oc_add(mfld, bval);
				if (amode) begin
					dec_indir = 1'b1;
					dec_jump = 1'b0;
				end
			end
			jump_ctrl_pkg::FN_IJUMP: begin
				// zero index or no designator falls through
				if (bsel != 2'h0 && bval != 15'h0000) begin
					dec_idx_wr = 1'b1;
					dec_idx_val = oc_add(bval, sub ? 15'h7ffe : 15'h0001);
					dec_target = mfld;
				end
			end
			jump_ctrl_pkg::FN_AJUMP: begin
				if (cmp_true) begin
					dec_target = mfld;
				end
			end
			default: begin
				// immediate operands are not address-resolved here
				dec_jump = 1'b0;
				dec_target = (bsel == 2'h0) ? mfld : oc_add(mfld, bval);
				// register-only codes never start an indirect chain
				dec_indir = amode && !((fn == 6'h04) || (fn == 6'h05) || (fn[5:3] == 3'h1));
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			jump_ctrl_pkg::ST_FETCH:  state_next = jump_ctrl_pkg::ST_DECODE;
			jump_ctrl_pkg::ST_DECODE: begin
				if (dec_halt) begin
					state_next = jump_ctrl_pkg::ST_HALTED;
				end else if (dec_rtj) begin
					state_next = jump_ctrl_pkg::ST_RTJ_WR;
				end else if (dec_jump) begin
					state_next = jump_ctrl_pkg::ST_FETCH;
				end else if (dec_indir) begin
					state_next = jump_ctrl_pkg::ST_INDIR;
				end else begin
					state_next = jump_ctrl_pkg::ST_EXEC;
				end
			end
			jump_ctrl_pkg::ST_INDIR: begin
				// keep chasing while mode bit set
				if (!amode) begin
					state_next = (func_reg[jump_ctrl_pkg::FUNC_HI:jump_ctrl_pkg::FUNC_LO]
						== jump_ctrl_pkg::FN_UJUMP) ? jump_ctrl_pkg::ST_FETCH
						: jump_ctrl_pkg::ST_EXEC;
				end
			end
			jump_ctrl_pkg::ST_RTJ_WR: state_next = jump_ctrl_pkg::ST_FETCH;
			jump_ctrl_pkg::ST_HALTED: begin
				if (go_reg) begin
					state_next = jump_ctrl_pkg::ST_FETCH;
				end
			end
			jump_ctrl_pkg::ST_EXEC: begin
				if (exec_done_in) begin
					state_next = jump_ctrl_pkg::ST_FETCH;
				end
			end
			default: state_next = jump_ctrl_pkg::ST_FETCH;
		endcase
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg <= jump_ctrl_pkg::ST_FETCH;
		end else begin
			state_reg <= state_next;
		end
	end

	// Instruction and fetch address tracking
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			func_reg <= 24'h000000;
			paddr_reg <= jump_ctrl_pkg::PADDR_RESET;
			fetch_addr_reg <= jump_ctrl_pkg::PADDR_RESET;
		end else begin
			if (state_reg == jump_ctrl_pkg::ST_DECODE) begin
				func_reg <= mem_rdata_in;
				paddr_reg <= fetch_addr_reg;
				if (dec_jump || dec_halt || dec_rtj) begin
					// load new address for next fetch
					fetch_addr_reg <= dec_target;
				end else begin
					fetch_addr_reg <= fetch_addr_reg + 15'h0001;
				end
			end else if (state_reg == jump_ctrl_pkg::ST_INDIR && !amode &&
					func_reg[jump_ctrl_pkg::FUNC_HI:jump_ctrl_pkg::FUNC_LO]
					== jump_ctrl_pkg::FN_UJUMP) begin
				fetch_addr_reg <= mfld;
			end
		end
	end

	// Effective address and indirection depth
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ea_reg <= 15'h0000;
			levels_reg <= 4'h0;
		end else if (state_reg == jump_ctrl_pkg::ST_DECODE) begin
			ea_reg <= (fn == jump_ctrl_pkg::FN_STOP) ? mfld : dec_target;
			levels_reg <= 4'h0;
		end else if (state_reg == jump_ctrl_pkg::ST_INDIR) begin
			ea_reg <= mfld;
			levels_reg <= levels_reg + 4'h1;
		end
	end

	// Index registers
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			for (int i = 1; i <= 3; i++) begin
				idx_reg[i] <= jump_ctrl_pkg::INDEX_RESET;
			end
		end else if (state_reg == jump_ctrl_pkg::ST_DECODE && dec_idx_wr) begin
			idx_reg[bsel] <= dec_idx_val;
		end else if (idx_wr_in && idx_sel_in != 2'h0) begin
			// Load from the execute unit, jump counting has priority
			idx_reg[idx_sel_in] <= idx_wdata_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Storage and status outputs
	always_comb begin
		mem_rd_out = (state_reg == jump_ctrl_pkg::ST_FETCH) ||
			(state_reg == jump_ctrl_pkg::ST_DECODE && (dec_indir || dec_rtj)) ||
			(state_reg == jump_ctrl_pkg::ST_INDIR && amode);
		mem_wr_out = (state_reg == jump_ctrl_pkg::ST_RTJ_WR);
		if (state_reg == jump_ctrl_pkg::ST_FETCH) begin
			mem_addr_out = fetch_addr_reg;
		end else if (state_reg == jump_ctrl_pkg::ST_DECODE) begin
			// Return jump reads its target word before rewriting it
			mem_addr_out = dec_rtj ? mfld : dec_target;
		end else if (state_reg == jump_ctrl_pkg::ST_INDIR) begin
			mem_addr_out = mfld;
		end else begin
			mem_addr_out = ea_reg;
		end
		// address part replaced only, target word's upper bits kept
		mem_wdata_out = {mem_rdata_in[23:15], paddr_reg + 15'h0001};
	end

	assign func_reg_out = func_reg;
	assign prog_addr_out = paddr_reg;
	assign exec_addr_out = ea_reg;
	assign operand_out = func_reg[14:0];
	assign exec_req_out = (state_reg == jump_ctrl_pkg::ST_EXEC);
	assign halted_out = (state_reg == jump_ctrl_pkg::ST_HALTED);
	assign index1_out = idx_reg[1];
	assign index2_out = idx_reg[2];
	assign index3_out = idx_reg[3];
	assign indir_levels_out = levels_reg;
endmodule : jump_stop_addressing_ctrl

// >>> common/jump_ctrl_pkg.sv
// Constants, field layout and state codes for the jump and addressing control
// Overview of operation
// - Immediate instructions use low word bits directly
// - Direct mode: address field plus optional index
// - Indirect mode: chase words until mode bit clear
// - One extra storage read per indirect level
// - Indirection and indexing are independent steps
// - Halt stops; restart fetches from address field
// - Key jump taken when selected console key set
// - Return jump stores return address, runs target+1
// - Unconditional jump uses full effective address
// - Count-up index jump: zero index falls through
// - Ones-complement counting never yields negative zero
// - Count-down index jump subtracts one, then jumps; zero index falls through
// - Negative zero index counts through whole range
// - Accumulator against zero, four condition codes
// - Accumulator against auxiliary, same four codes
// - Taken jump reloads program address, fetches target
// - Program address holds current instruction location
// - Six-bit function code from upper word bits
// - Two-bit index designator, zero means none
package jump_ctrl_pkg;
	localparam int WORD_W    = 24;           // Storage word width
	localparam int ADDR_W    = 15;           // Address width
	localparam int FUNC_HI   = 23;           // Function code top bit
	localparam int FUNC_LO   = 18;           // Function code bottom bit
	localparam int MODE_BIT  = 17;           // Addressing-mode bit
	localparam int IDX_HI    = 16;           // Index designator top bit
	localparam int IDX_LO    = 15;           // Index designator bottom bit
	localparam int COND_HI   = 17;           // Jump condition field top bit
	localparam int COND_LO   = 15;           // Jump condition field bottom bit
	localparam int SUB_BIT   = 17;           // Variant bit for 02 and 03
	localparam int ZCOND_HI  = 16;           // Two-bit compare code top bit
	localparam int ZCOND_LO  = 15;           // Two-bit compare code bottom bit
	localparam logic [5:0] FN_STOP   = 6'h00;   // Halt, key jump, return jump
	localparam logic [5:0] FN_UJUMP  = 6'h01;   // Unconditional jump
	localparam logic [5:0] FN_IJUMP  = 6'h02;   // Index count jumps
	localparam logic [5:0] FN_AJUMP  = 6'h03;   // Accumulator compare jumps
	localparam logic [2:0] SEL_HALT  = 3'h0;    // Condition code for halt
	localparam logic [2:0] SEL_RTJ   = 3'h7;    // Condition code for return jump
	localparam logic [1:0] cond_equal            = 2'h0;
	localparam logic [1:0] cond_unequal          = 2'h1;
	localparam logic [1:0] cond_greater_or_equal = 2'h2;
	localparam logic [1:0] cond_less             = 2'h3;
	localparam logic [14:0] PADDR_RESET = 15'h0000; // Program address after clear
	localparam logic [14:0] INDEX_RESET = 15'h0000; // Index registers after clear

	// Control sequence states
	typedef enum logic [2:0] {
		ST_FETCH   = 3'b000,   // Request instruction word
		ST_DECODE  = 3'b001,   // Instruction word arrives, decode
		ST_INDIR   = 3'b010,   // Indirect word arrives
		ST_RTJ_WR  = 3'b011,   // Return jump write of address part
		ST_HALTED  = 3'b100,   // Stopped, waiting for restart
		ST_EXEC    = 3'b101    // Effective address handed to execute unit
	} ctrl_state_e;
endpackage : jump_ctrl_pkg

// >>> testbench/jump_ctrl_props.sv
// Port-level checks on the jump and addressing control
`timescale 1ns/1ns
module jump_ctrl_props (
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire logic        restart_in,
	input wire logic [23:0] acc_in,
	input wire logic        mem_rd_out,
	input wire logic        mem_wr_out,
	input wire logic [14:0] mem_addr_out,
	input wire logic [23:0] mem_wdata_out,
	input wire logic [23:0] mem_rdata_in,
	input wire logic [23:0] func_reg_out,
	input wire logic [14:0] prog_addr_out,
	input wire logic        halted_out,
	input wire logic        exec_req_out
);
	// Accumulator test for one compare code, both zeros alike for equal and unequal
	function automatic logic acc_test(input logic [1:0] c, input logic [23:0] a);
		logic z;
		z = (a == 24'h000000) || (a == 24'hffffff);
		if (c == jump_ctrl_pkg::cond_equal) return z;
		if (c == jump_ctrl_pkg::cond_unequal) return !z;
		return (c == jump_ctrl_pkg::cond_greater_or_equal) ? !a[23] : a[23];
	endfunction : acc_test
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////////////////
	a_word_from_store: assert property (
		$changed(func_reg_out) |-> $past(mem_rd_out, 2) && func_reg_out == $past(mem_rdata_in))
		else $error("function register not loaded from storage");
	a_paddr_tracks_fetch: assert property (
		$changed(prog_addr_out) |-> prog_addr_out == $past(mem_addr_out, 2))
		else $error("program address differs from fetch address");
	a_rtj_addr_part: assert property (
		mem_wr_out |-> func_reg_out[23:15] == {jump_ctrl_pkg::FN_STOP, jump_ctrl_pkg::SEL_RTJ}
		&& mem_addr_out == func_reg_out[14:0] && mem_wdata_out[14:0] == prog_addr_out + 15'h0001
		&& mem_wdata_out[23:15] == mem_rdata_in[23:15])
		else $error("return jump write wrong");
	a_rtj_then_next: assert property (
		mem_wr_out |=> mem_rd_out && mem_addr_out == $past(mem_addr_out) + 15'h0001)
		else $error("return jump did not continue at target plus one");
	a_halt_only_stop: assert property (
		halted_out |-> func_reg_out[23:15] == {jump_ctrl_pkg::FN_STOP, jump_ctrl_pkg::SEL_HALT})
		else $error("stopped without halt instruction");
	a_halt_holds: assert property (
		(!restart_in)[*3] ##0 halted_out |=> halted_out)
		else $error("left halt without restart");
	a_zero_compare_target: assert property (
		$changed(func_reg_out) && func_reg_out[23:17] == {jump_ctrl_pkg::FN_AJUMP, 1'b0}
		&& $stable(acc_in) |-> mem_rd_out && mem_addr_out == (acc_test(func_reg_out[16:15],
		acc_in) ? func_reg_out[14:0] : prog_addr_out + 15'h0001))
		else $error("zero compare jump went to wrong address");
	a_indirect_first_read: assert property (
		$changed(func_reg_out) && func_reg_out[23:15] == {jump_ctrl_pkg::FN_UJUMP, 3'h4}
		|-> $past(mem_rd_out) && $past(mem_addr_out) == func_reg_out[14:0])
		else $error("indirect jump did not read address field");
	a_rtj_reads_target: assert property (
		mem_wr_out |-> $past(mem_rd_out) && $past(mem_addr_out) == mem_addr_out)
		else $error("return jump did not read its target first");
	a_imm_no_chain: assert property (
		$changed(func_reg_out) && func_reg_out[23:20] == 4'h3 |-> exec_req_out && !mem_rd_out)
		else $error("register-only instruction started a storage read");
	c_rtj_write: cover property (mem_wr_out);
	c_halt_leave: cover property (halted_out ##1 !halted_out);
	c_exec_seen: cover property (exec_req_out);
endmodule : jump_ctrl_props
bind jump_stop_addressing_ctrl jump_ctrl_props chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.restart_in(restart_in), .acc_in(acc_in), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
	.mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
	.func_reg_out(func_reg_out), .prog_addr_out(prog_addr_out), .halted_out(halted_out),
	.exec_req_out(exec_req_out));

// >>> testbench/core_store_model.sv
// Core storage model answering reads one cycle later
`timescale 1ns/1ns
module core_store_model (
	input  wire logic        clk_in,
	input  wire logic        rd_in,
	input  wire logic        wr_in,
	input  wire logic [14:0] addr_in,
	input  wire logic [23:0] wdata_in,
	output logic      [23:0] rdata_out
);
	logic [23:0] mem [0:32767];   // Storage words, bench preloads them
	// Plain always: the bench also writes the array
	always @(posedge clk_in) begin
		if (rd_in) begin
			rdata_out <= mem[addr_in];
		end else begin
			rdata_out <= ~rdata_out;   // Idle bus toggles, never stale
		end
		if (wr_in) begin
			mem[addr_in] <= wdata_in;
		end
	end
endmodule : core_store_model

// >>> testbench/tb.sv
// Self-checking bench for the jump and addressing control
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
	$display("BAD %s expected %h seen %h", nm, ex, got); end end
module tb;
	typedef struct {logic [23:0] ins, acc, aux; logic [14:0] tgt; int cyc;} row_s;
	logic        clk_in, sys_rst_in, restart_in, exec_done_in, mem_rd_out, mem_wr_out;
	logic        exec_req_out, halted_out, idx_wr_in;
	logic [1:0]  idx_sel_in;
	logic [1:0]  ld_sel = 2'h0;
	logic [14:0] ld_val = 15'h0000;
	logic [14:0] idx_wdata_in, index1_out, index2_out, index3_out;
	logic [5:0]  console_keys_in;
	logic [14:0] mem_addr_out, prog_addr_out, exec_addr_out, operand_out;
	logic [23:0] acc_in, aux_in, mem_wdata_out, mem_rdata_in, func_reg_out;
	logic [3:0]  indir_levels_out;
	int          num_errors = 0;
	int          n_compared = 0;
	int          c;
	// Word at zero, registers, next location, edges to next word
	row_s rows [16] = '{
		'{24'h040040, 24'h0, 24'h0, 15'h040, 2}, '{24'h060300, 24'h0, 24'h0, 15'h300, 3},
		'{24'h060100, 24'h0, 24'h0, 15'h200, 4}, '{24'h080070, 24'h0, 24'h0, 15'h001, 2},
		'{24'h088070, 24'h0, 24'h0, 15'h001, 2}, '{24'h0b0070, 24'h0, 24'h0, 15'h001, 2},
		'{24'h0c0080, 24'hffffff, 24'h0, 15'h080, 2}, '{24'h0c8080, 24'h0, 24'h0, 15'h001, 2},
		'{24'h0d0080, 24'hffffff, 24'h0, 15'h001, 2}, '{24'h0d0080, 24'h5, 24'h0, 15'h080, 2},
		'{24'h0d8080, 24'h800001, 24'h0, 15'h080, 2}, '{24'h0e0080, 24'h0, 24'hffffff, 15'h080, 2},
		'{24'h0e8080, 24'h5, 24'h5, 15'h001, 2}, '{24'h0f0080, 24'h7, 24'h3, 15'h080, 2},
		'{24'h0f8080, 24'h3, 24'h7, 15'h080, 2}, '{24'h038060, 24'h0, 24'h0, 15'h061, 3}};
	jump_stop_addressing_ctrl dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.console_keys_in(console_keys_in), .restart_in(restart_in), .acc_in(acc_in),
		.aux_in(aux_in), .exec_done_in(exec_done_in), .mem_rd_out(mem_rd_out),
		.mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_rdata_in(mem_rdata_in), .func_reg_out(func_reg_out), .prog_addr_out(prog_addr_out),
		.exec_addr_out(exec_addr_out), .operand_out(operand_out), .exec_req_out(exec_req_out),
		.halted_out(halted_out), .index1_out(index1_out), .index2_out(index2_out),
		.index3_out(index3_out), .idx_wr_in(idx_wr_in), .idx_sel_in(idx_sel_in),
		.idx_wdata_in(idx_wdata_in), .indir_levels_out(indir_levels_out));
	core_store_model mem_u (.clk_in(clk_in), .rd_in(mem_rd_out), .wr_in(mem_wr_out),
		.addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
	always #2 clk_in = ~clk_in;
	// Filler: direct storage-reference word naming its own location
	function automatic logic [23:0] fill(input logic [14:0] a);
		return {6'h20, 3'h0, a};
	endfunction : fill
	// Clear, place a word at zero, wait until it is decoded
	task automatic run(input logic [23:0] ins, acc, aux, input logic [5:0] keys);
		int n;
		n = 0;
		mem_u.mem[0] = ins;
		mem_u.mem[15'h060] = fill(15'h060);
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		acc_in <= acc;
		aux_in <= aux;
		console_keys_in <= keys;
		idx_sel_in <= ld_sel;
		idx_wdata_in <= ld_val;
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		idx_wr_in <= 1'b1;
		@(posedge clk_in);
		idx_wr_in <= 1'b0;
		while (func_reg_out !== ins && n < 40) begin
			@(negedge clk_in);
			n++;
		end
		`CHK("first_word", ins, func_reg_out)
	endtask : run
	// Count edges until the function register takes a new word
	task automatic next_word(output int cyc);
		logic [23:0] w;
		w = func_reg_out;
		cyc = 0;
		while (func_reg_out === w && cyc < 40) begin
			@(negedge clk_in);
			cyc++;
		end
	endtask : next_word
	// Run a non-jump word until it is handed to execution
	task automatic go_exec(input logic [23:0] ins);
		int n;
		n = 0;
		run(ins, 24'h0, 24'h0, 6'h00);
		while (exec_req_out !== 1'b1 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		`CHK("exec_req", 1'b1, exec_req_out)
	endtask : go_exec
	// Preload one index, run a word at zero, check target and index
	task automatic idx_case(input logic [23:0] ins, input logic [1:0] s,
			input logic [14:0] v, tgt, ex);
		logic [14:0] got;
		ld_sel = s;
		ld_val = v;
		run(ins, 24'h0, 24'h0, 6'h00);
		next_word(c);
		ld_sel = 2'h0;
		got = (s == 2'h1) ? index1_out : (s == 2'h2) ? index2_out : index3_out;
		`CHK("idx_paddr", tgt, prog_addr_out)
		`CHK("idx_value", ex, got)
	endtask : idx_case
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#80000;
		num_errors++;
		wrap_up();
	end
	initial begin
		clk_in = 1'b0;
		sys_rst_in = 1'b1;
		restart_in = 1'b0;
		exec_done_in = 1'b0;
		idx_wr_in = 1'b0;
		idx_sel_in = 2'h0;
		idx_wdata_in = 15'h0000;
		console_keys_in = 6'h00;
		acc_in = 24'h0;
		aux_in = 24'h0;
		for (int a = 0; a < 32768; a++) mem_u.mem[a] = fill(a[14:0]);
		mem_u.mem[15'h100] = 24'h020200;
		foreach (rows[i]) begin
			run(rows[i].ins, rows[i].acc, rows[i].aux, 6'h00);
			next_word(c);
			`CHK("next_paddr", rows[i].tgt, prog_addr_out)
			`CHK("next_word", fill(rows[i].tgt), func_reg_out)
			`CHK("edges", rows[i].cyc, c)
			$display("row %0d done", i);
		end
		`CHK("link_addr", 15'h0001, mem_u.mem[15'h060][14:0])
		`CHK("link_upper", 9'h100, mem_u.mem[15'h060][23:15])
		for (int j = 1; j <= 6; j++) begin
			for (int t = 0; t < 2; t++) begin
				run({6'h00, j[2:0], 15'h050}, 24'h0, 24'h0,
					t ? (6'h01 << (j - 1)) : ~(6'h01 << (j - 1)));
				next_word(c);
				`CHK("key_paddr", t ? 15'h050 : 15'h001, prog_addr_out)
			end
		end
		$display("key jumps done");
		run(24'h000090, 24'h0, 24'h0, 6'h00);
		`CHK("halted", 1'b1, halted_out)
		repeat (10) @(negedge clk_in);
		`CHK("still_halted", 1'b1, halted_out)
		`CHK("halt_paddr", 15'h0000, prog_addr_out)
		@(posedge clk_in);
		restart_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		restart_in <= 1'b0;
		repeat (10) @(negedge clk_in);
		`CHK("restart_paddr", 15'h0090, prog_addr_out)
		$display("halt done");
		go_exec(24'h800123);
		`CHK("direct_addr", 15'h0123, exec_addr_out)
		`CHK("direct_levels", 4'h0, indir_levels_out)
		go_exec(24'h338100);
		`CHK("operand", 15'h0100, operand_out)
		`CHK("imm_levels", 4'h0, indir_levels_out)
		go_exec(24'h820100);
		`CHK("indir_addr", 15'h0200, exec_addr_out)
		`CHK("indir_levels", 4'h2, indir_levels_out)
		@(posedge clk_in);
		exec_done_in <= 1'b1;
		@(posedge clk_in);
		exec_done_in <= 1'b0;
		@(negedge clk_in);
		`CHK("exec_release", 1'b0, exec_req_out)
		$display("exec cases done");
		idx_case(24'h088050, 2'h1, 15'h0005, 15'h050, 15'h0006);
		idx_case(24'h088050, 2'h1, 15'h7ffe, 15'h050, 15'h0000);
		idx_case(24'h088050, 2'h1, 15'h7fff, 15'h050, 15'h0001);
		idx_case(24'h0b0050, 2'h2, 15'h0003, 15'h050, 15'h0002);
		idx_case(24'h0b0050, 2'h2, 15'h7fff, 15'h050, 15'h7ffe);
		idx_case(24'h0b8050, 2'h3, 15'h0001, 15'h050, 15'h0000);
		idx_case(24'h058040, 2'h3, 15'h0002, 15'h042, 15'h0002);
		idx_case(24'h0680fe, 2'h1, 15'h0002, 15'h200, 15'h0002);
		ld_sel = 2'h1;
		ld_val = 15'h0003;
		go_exec(24'h808100);
		ld_sel = 2'h0;
		`CHK("indexed_addr", 15'h0103, exec_addr_out)
		$display("index cases done");
		wrap_up();
	end
endmodule : tb
